//--- ibtq_props.sv
module ibtq_props (
  input wire logic clk,
  input wire logic srst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [ibtq_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic stream_close,
  input wire logic tx_valid,
  input wire logic [ibtq_pkg::DATA_W-1:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_ready
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response not held");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
  a_addr_held: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("second address taken while one is held");
  a_read_gate: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated after handshake");
  // A stalled word must stay put, or the host sees a torn block; only a close may drop it.
  a_tx_stall: assert property (tx_valid && !tx_ready && !stream_close |=> tx_valid &&
    $stable(tx_data) && $stable(tx_last)) else $error("output word changed while stalled");
  a_close_flush: assert property (stream_close |-> ##2 !tx_valid)
    else $error("output still valid after close");
endmodule

//--- ibtq_sink.sv
module ibtq_sink (
  input wire logic clk,
  input wire logic slow,
  input wire logic tx_valid,
  input wire logic [ibtq_pkg::DATA_W-1:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready = 1'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [ibtq_pkg::DATA_W-1:0] seen[$];
  int lasts = 0;
  int ends[$];
  logic [1:0] ph = 2'h0;
  // A slow host takes one word in four, so the output buffer fills and must hold its words.
  always @(posedge clk)
  begin
    ph <= ph + 2'h1;
    tx_ready <= !slow || ph == 2'h3;
    if (tx_valid && tx_ready)
    begin
      seen.push_back(tx_data);
      lasts += int'(tx_last);
      if (tx_last)
        ends.push_back(seen.size());
    end
  end
endmodule

//--- ibtq_skid.sv
package ibtq_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int DEF_QUEUE_BLOCKS = 4;
  localparam int DEF_SLOT_WORDS = 64;
  localparam int DEF_PKT_WORDS = 16;
  localparam int CNT_W = 16;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_BLOCKS = 8'h04;
  localparam logic [7:0] OFS_CMD = 8'h08;
  localparam logic [7:0] OFS_CAPACITY = 8'h0C;
  localparam logic [7:0] OFS_OCCUPANCY = 8'h10;
  localparam logic [7:0] OFS_DROPPED = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam int CTRL_METHOD_LSB = 0;
  localparam int CTRL_OP_BIT = 2;
  localparam int CTRL_POLICY_BIT = 3;
  localparam int CMD_GO_BIT = 0;
  localparam int CMD_HALT_BIT = 1;
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_TX_BIT = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] METHOD_ILLEGAL = 2'h3;
  localparam logic [CNT_W-1:0] BLOCKS_RESET = 16'h0001;
  typedef enum logic [1:0] {METHOD_BASIC, METHOD_AUTO, METHOD_USER} ibtq_method_e;
  typedef enum logic {OP_CONTINUOUS, OP_MULTI} ibtq_op_e;
  typedef enum logic {POLICY_FIFO} ibtq_policy_e;
endpackage

module ibtq_skid #(
  parameter int W = 33
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic flush,
  input wire logic s_valid,
  input wire logic [W-1:0] s_data,
  output logic s_ready,
  output logic m_valid,
  output logic [W-1:0] m_data,
  input wire logic m_ready
);
  typedef struct packed {
    logic [1:0] cnt;
    logic [W-1:0] e0;
    logic [W-1:0] e1;
  } ibtq_skid_s;

  ibtq_skid_s r_reg;
  ibtq_skid_s r_next;

  assign s_ready = (r_reg.cnt != 2'h2);
  assign m_valid = (r_reg.cnt != 2'h0);
  assign m_data = r_reg.e0;

  always_comb
  begin
    r_next = r_reg;
    if (m_valid && m_ready)
    begin
      r_next.e0 = r_reg.e1;
      r_next.cnt = r_next.cnt - 2'h1;
    end
    if (s_valid && s_ready)
    begin
      if (r_next.cnt == 2'h0)
        r_next.e0 = s_data;
      else
        r_next.e1 = s_data;
      r_next.cnt = r_next.cnt + 2'h1;
    end
    if (flush)
      r_next.cnt = 2'h0;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end
endmodule

//--- ibtq_tb.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, srst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, blk_valid = 0, blk_last = 0, stream_close = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, tx_valid;
  logic tx_last, tx_ready, slow = 0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, blk_data = 32'h0, tx_data, rv;
  logic [31:0] exp_q[$];
  int exp_ends[$];
  int fail_count = 0, checks = 0, cyc = 0, nb = 0;
  ibtq_transfer_queue #(.QUEUE_BLOCKS(2), .SLOT_WORDS(8), .PKT_WORDS(4)) DUT (.*);
  ibtq_sink sink (.*);
  always #50 clk = ~clk;
  task automatic print_verdict();
    if (fail_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      print_verdict();
    end
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ah = 0, dh = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge clk);
      ah |= s_axi_awready;
      dh |= s_axi_wready;
      if (ah) s_axi_awvalid <= 1'h0;
      if (dh) s_axi_wvalid <= 1'h0;
    end
    while (!(ah && dh));
    // Bready and rready stay high between calls, so back to back calls never assign twice.
    while (!s_axi_bvalid) @(posedge clk);
    br = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge clk); while (!s_axi_rvalid);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk("register", rv, e);
  endtask
  task automatic push(input logic [31:0] b, input int n, input logic l);
    for (int i = 0; i < n; i++)
    begin
      blk_valid <= 1'h1;
      blk_data <= b + i;
      blk_last <= l && i == n - 1;
      @(posedge clk);
    end
    blk_valid <= 1'h0;
    blk_last <= 1'h0;
    @(posedge clk);
  endtask
  task automatic ex(input logic [31:0] b, input int n);
    for (int i = 0; i < n; i++)
      exp_q.push_back(b + i);
    nb++;
    exp_ends.push_back(exp_q.size());
  endtask
  // Waits past the last expected word so that a word sent too many is also seen.
  task automatic drain();
    while (sink.seen.size() < exp_q.size()) @(posedge clk);
    repeat (40) @(posedge clk);
    chk("words", sink.seen.size(), exp_q.size());
    chk("blocks", sink.lasts, nb);
    foreach (exp_q[i]) chk("word", sink.seen[i], exp_q[i]);
    foreach (exp_ends[i]) chk("block end", sink.ends[i], exp_ends[i]);
  endtask
  task automatic t_regs();
    rc(ibtq_pkg::OFS_CTRL, 32'h0);
    rc(ibtq_pkg::OFS_BLOCKS, 32'h1);
    rc(ibtq_pkg::OFS_CAPACITY, 32'h2);
    rc(ibtq_pkg::OFS_OCCUPANCY, 32'h0);
    rc(ibtq_pkg::OFS_DROPPED, 32'h0);
    rc(ibtq_pkg::OFS_CMD, 32'h0);
    wr(ibtq_pkg::OFS_CAPACITY, 32'h9);
    chk("write response", br, ibtq_pkg::RESP_OKAY);
    rc(ibtq_pkg::OFS_CAPACITY, 32'h2);
    wr(8'h1C, 32'h1);
    chk("unmapped write", br, ibtq_pkg::RESP_SLVERR);
    rd(8'h1C);
    chk("unmapped", rr, ibtq_pkg::RESP_SLVERR);
    // Automatic must act as basic; method value 3 is refused and leaves it unchanged.
    wr(ibtq_pkg::OFS_CTRL, 32'h1);
    wr(ibtq_pkg::OFS_CTRL, 32'h3);
    rc(ibtq_pkg::OFS_CTRL, 32'h1);
    wr(ibtq_pkg::OFS_CMD, 32'h1);
    rc(ibtq_pkg::OFS_STATUS, 32'h0);
  endtask
  task automatic t_basic();
    slow <= 1'h1;
    wr(ibtq_pkg::OFS_CMD, 32'h2);
    push(32'h100, 5, 1'h0);
    repeat (20) @(posedge clk);
    chk("early", sink.seen.size() > 0, 1);
    push(32'h105, 1, 1'h1);
    push(32'h200, 2, 1'h1);
    ex(32'h100, 6);
    ex(32'h200, 2);
    drain();
  endtask
  task automatic t_user();
    wr(ibtq_pkg::OFS_CTRL, 32'h2);
    push(32'h300, 2, 1'h1);
    push(32'h400, 2, 1'h1);
    drain();
    rc(ibtq_pkg::OFS_OCCUPANCY, 32'h2);
    push(32'h500, 2, 1'h1);
    rc(ibtq_pkg::OFS_OCCUPANCY, 32'h2);
    rc(ibtq_pkg::OFS_DROPPED, 32'h1);
    wr(ibtq_pkg::OFS_CMD, 32'h1);
    ex(32'h400, 2);
    ex(32'h500, 2);
    drain();
  endtask
  task automatic t_halt();
    push(32'h600, 8, 1'h1);
    push(32'h700, 2, 1'h1);
    wr(ibtq_pkg::OFS_CMD, 32'h2);
    ex(32'h600, 8);
    drain();
    rc(ibtq_pkg::OFS_OCCUPANCY, 32'h1);
  endtask
  task automatic t_multi();
    wr(ibtq_pkg::OFS_CTRL, 32'h6);
    push(32'h800, 2, 1'h1);
    wr(ibtq_pkg::OFS_BLOCKS, 32'h1);
    wr(ibtq_pkg::OFS_CMD, 32'h1);
    ex(32'h700, 2);
    drain();
    rc(ibtq_pkg::OFS_OCCUPANCY, 32'h1);
    wr(ibtq_pkg::OFS_CTRL, 32'h2);
    wr(ibtq_pkg::OFS_BLOCKS, 32'h0);
    wr(ibtq_pkg::OFS_CMD, 32'h1);
    ex(32'h800, 2);
    drain();
  endtask
  task automatic t_close();
    wr(ibtq_pkg::OFS_CMD, 32'h2);
    push(32'h900, 2, 1'h1);
    rc(ibtq_pkg::OFS_OCCUPANCY, 32'h1);
    stream_close <= 1'h1;
    @(posedge clk);
    stream_close <= 1'h0;
    rc(ibtq_pkg::OFS_OCCUPANCY, 32'h0);
    wr(ibtq_pkg::OFS_CMD, 32'h1);
    drain();
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    srst <= 1'h0;
    @(posedge clk);
    t_regs();
    t_basic();
    t_user();
    t_halt();
    t_multi();
    t_close();
    print_verdict();
  end
endmodule
bind ibtq_transfer_queue ibtq_props u_props (.*);

//--- ibtq_transfer_queue.sv
// Notes on behaviour
// - Basic/automatic send a block once one packet of words is buffered or the block is complete.
// - User-controlled method releases blocks only per commands and operation mode.
// - Continuous mode streams back to back, gated by go and halt commands.
// - Multi-block mode sends exactly the programmed block count, then stops.
// - Block count is used only in multi-block mode.
// - Read-only queue capacity value.
// - Read-only occupancy, tracks enqueue and transmit start.
// - Read-only counter of blocks dropped before transmission.
// - Queue policy is first-in-first-out only; oldest block goes next.
// - Go command starts streaming queued blocks.
// - Halt command stops after the block in progress completes.
// - Go and halt act only under the user-controlled method.
// - New block into full queue overwrites oldest untransmitted block, counts drop.
// - Acquisition start or stop leaves queue and transfer state untouched.
// - Closing the stream empties the queue and cancels transmission.
module ibtq_transfer_queue #(
  parameter int QUEUE_BLOCKS = ibtq_pkg::DEF_QUEUE_BLOCKS,
  parameter int SLOT_WORDS = ibtq_pkg::DEF_SLOT_WORDS,
  parameter int PKT_WORDS = ibtq_pkg::DEF_PKT_WORDS
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [ibtq_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ibtq_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ibtq_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [ibtq_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic blk_valid,
  input wire logic [ibtq_pkg::DATA_W-1:0] blk_data,
  input wire logic blk_last,
  input wire logic stream_close,
  output logic tx_valid,
  output logic [ibtq_pkg::DATA_W-1:0] tx_data,
  output logic tx_last,
  input wire logic tx_ready
);
  // One spare slot for the block on the wire and one for the block being written,
  // so the first overwrite during a transfer misses the slot being read; a second drop in the same transfer can land on it.
  localparam int NSLOT = QUEUE_BLOCKS + 2;
  localparam int SW = $clog2(NSLOT);
  localparam int LW = $clog2(SLOT_WORDS + 1);
  localparam int CW = $clog2(QUEUE_BLOCKS + 1);
  localparam int MW = $clog2(NSLOT * SLOT_WORDS);
  localparam int AW = ibtq_pkg::ADDR_W;
  localparam int DW = ibtq_pkg::DATA_W;
  localparam int NW = ibtq_pkg::CNT_W;

  typedef struct packed {
    ibtq_pkg::ibtq_method_e method;
    ibtq_pkg::ibtq_op_e op;
    logic [NW-1:0] blocks_to_send;
    logic running;
    logic [NW-1:0] remaining;
    logic [SW-1:0] head;
    logic [SW-1:0] tail;
    logic [CW-1:0] queue_occupancy;
    logic [DW-1:0] dropped_block_count;
    logic wr_busy;
    logic [SW-1:0] wr_slot;
    logic [LW-1:0] wr_idx;
    logic tx_active;
    logic [SW-1:0] tx_slot;
    logic [LW-1:0] rd_idx;
    logic [NSLOT-1:0][LW-1:0] slot_len;
    logic [NSLOT-1:0] slot_done;
    logic aw_held;
    logic [AW-1:0] awaddr;
    logic w_held;
    logic [DW-1:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [DW-1:0] rdata;
    logic [1:0] rresp;
  } ibtq_state_s;

  ibtq_state_s r_reg;
  ibtq_state_s r_next;
  logic [DW-1:0] mem [NSLOT*SLOT_WORDS];
  logic mem_we;
  logic [MW-1:0] mem_waddr;
  logic [MW-1:0] mem_raddr;
  logic push_valid;
  logic push_last;
  logic push_ready;
  logic [DW:0] skid_out;

  function automatic logic [SW-1:0] slot_inc(input logic [SW-1:0] p);
    slot_inc = (p == SW'(NSLOT - 1)) ? '0 : p + 1'b1;
  endfunction

  function automatic logic [MW-1:0] word_addr(input logic [SW-1:0] s, input logic [LW-1:0] i);
    word_addr = MW'(int'(s) * SLOT_WORDS + int'(i));
  endfunction

  assign s_axi_awready = !r_reg.aw_held;
  assign s_axi_wready = !r_reg.w_held;
  assign s_axi_bvalid = r_reg.bvalid;
  assign s_axi_bresp = r_reg.bresp;
  assign s_axi_arready = !r_reg.rvalid;
  assign s_axi_rvalid = r_reg.rvalid;
  assign s_axi_rdata = r_reg.rdata;
  assign s_axi_rresp = r_reg.rresp;
  assign tx_data = skid_out[DW-1:0];
  assign tx_last = skid_out[DW];
  assign mem_raddr = word_addr(r_reg.tx_slot, r_reg.rd_idx);

  // Reads on the wire proceed only over words already written, so a block is
  // cut through while its tail is still arriving.
  always_comb
  begin
    push_valid = r_reg.tx_active && (r_reg.rd_idx < r_reg.slot_len[r_reg.tx_slot]);
    push_last = r_reg.slot_done[r_reg.tx_slot] &&
                (LW'(r_reg.rd_idx + 1'b1) == r_reg.slot_len[r_reg.tx_slot]);
  end

  always_comb
  begin
    logic gate;
    logic tx_start;
    logic new_blk;
    logic drop;
    logic [SW-1:0] slot;
    logic [LW-1:0] idx;
    logic wr_do;
    logic [AW-1:0] wa;
    logic [DW-1:0] rd;
    logic [1:0] rr;
    gate = 1'b0;
    tx_start = 1'b0;
    new_blk = 1'b0;
    drop = 1'b0;
    slot = '0;
    idx = '0;
    wr_do = 1'b0;
    wa = '0;
    rd = '0;
    rr = ibtq_pkg::RESP_OKAY;
    r_next = r_reg;
    mem_we = 1'b0;
    mem_waddr = '0;

    gate = (r_reg.method != ibtq_pkg::METHOD_USER) || r_reg.running;
    tx_start = gate && !r_reg.tx_active && (r_reg.queue_occupancy != '0) &&
               (r_reg.slot_done[r_reg.head] ||
                (r_reg.slot_len[r_reg.head] >= LW'(PKT_WORDS)));
    if (tx_start)
    begin
      r_next.tx_active = 1'b1;
      r_next.tx_slot = r_reg.head;
      r_next.rd_idx = '0;
      if (r_reg.method == ibtq_pkg::METHOD_USER && r_reg.op == ibtq_pkg::OP_MULTI)
      begin
        r_next.remaining = r_reg.remaining - 1'b1;
        if (r_reg.remaining == NW'(1))
          r_next.running = 1'b0;
      end
    end
    if (push_valid && push_ready)
    begin
      r_next.rd_idx = r_reg.rd_idx + 1'b1;
      if (push_last)
        r_next.tx_active = 1'b0;
    end

    // Block arrival runs whatever acquisition is doing; it never touches the gate.
    if (blk_valid)
    begin
      new_blk = !r_reg.wr_busy;
      drop = new_blk && ((r_reg.queue_occupancy - CW'(tx_start)) == CW'(QUEUE_BLOCKS));
      slot = new_blk ? r_reg.tail : r_reg.wr_slot;
      idx = new_blk ? '0 : r_reg.wr_idx;
      if (new_blk)
      begin
        r_next.wr_slot = r_reg.tail;
        r_next.tail = slot_inc(r_reg.tail);
        r_next.slot_done[r_reg.tail] = 1'b0;
        r_next.slot_len[r_reg.tail] = '0;
      end
      // Words beyond a slot are discarded; the block is truncated, not split.
      if (idx < LW'(SLOT_WORDS))
      begin
        mem_we = 1'b1;
        mem_waddr = word_addr(slot, idx);
        r_next.slot_len[slot] = idx + 1'b1;
        r_next.wr_idx = idx + 1'b1;
      end
      r_next.wr_busy = !blk_last;
      if (blk_last)
        r_next.slot_done[slot] = 1'b1;
    end
    if (drop)
      r_next.dropped_block_count = r_reg.dropped_block_count + 1'b1;
    r_next.head = (tx_start || drop) ? slot_inc(r_reg.head) : r_reg.head;
    r_next.queue_occupancy = r_reg.queue_occupancy - CW'(tx_start) +
                             CW'(new_blk && !drop);

    if (s_axi_awvalid && !r_reg.aw_held)
    begin
      r_next.aw_held = 1'b1;
      r_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !r_reg.w_held)
    begin
      r_next.w_held = 1'b1;
      r_next.wdata = s_axi_wdata;
      r_next.wstrb = s_axi_wstrb;
    end
    if (r_reg.bvalid && s_axi_bready)
      r_next.bvalid = 1'b0;
    wr_do = r_reg.aw_held && r_reg.w_held && !r_reg.bvalid;
    if (wr_do)
    begin
      wa = {r_reg.awaddr[AW-1:2], 2'h0};
      r_next.aw_held = 1'b0;
      r_next.w_held = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp = ibtq_pkg::RESP_OKAY;
      unique case (wa)
        ibtq_pkg::OFS_CTRL:
        begin
          if (r_reg.wstrb[0])
          begin
            if (r_reg.wdata[ibtq_pkg::CTRL_METHOD_LSB +: 2] != ibtq_pkg::METHOD_ILLEGAL)
              r_next.method = ibtq_pkg::ibtq_method_e'(r_reg.wdata[ibtq_pkg::CTRL_METHOD_LSB +: 2]);
            r_next.op = ibtq_pkg::ibtq_op_e'(r_reg.wdata[ibtq_pkg::CTRL_OP_BIT]);
          end
        end
        ibtq_pkg::OFS_BLOCKS:
        begin
          if (r_reg.wstrb[0])
            r_next.blocks_to_send[7:0] = r_reg.wdata[7:0];
          if (r_reg.wstrb[1])
            r_next.blocks_to_send[15:8] = r_reg.wdata[15:8];
        end
        ibtq_pkg::OFS_CMD:
        begin
          if (r_reg.wstrb[0] && r_reg.method == ibtq_pkg::METHOD_USER)
          begin
            if (r_reg.wdata[ibtq_pkg::CMD_GO_BIT])
            begin
              r_next.remaining = r_reg.blocks_to_send;
              r_next.running = (r_reg.op == ibtq_pkg::OP_CONTINUOUS) ||
                               (r_reg.blocks_to_send != '0);
            end
            // Halt only closes the gate; a block already on the wire runs out.
            if (r_reg.wdata[ibtq_pkg::CMD_HALT_BIT])
              r_next.running = 1'b0;
          end
        end
        ibtq_pkg::OFS_CAPACITY, ibtq_pkg::OFS_OCCUPANCY, ibtq_pkg::OFS_DROPPED,
        ibtq_pkg::OFS_STATUS:
          r_next.bresp = ibtq_pkg::RESP_OKAY;
        default:
          r_next.bresp = ibtq_pkg::RESP_SLVERR;
      endcase
    end

    if (r_reg.rvalid && s_axi_rready)
      r_next.rvalid = 1'b0;
    if (s_axi_arvalid && !r_reg.rvalid)
    begin
      unique case ({s_axi_araddr[AW-1:2], 2'h0})
        ibtq_pkg::OFS_CTRL:
        begin
          rd[ibtq_pkg::CTRL_METHOD_LSB +: 2] = r_reg.method;
          rd[ibtq_pkg::CTRL_OP_BIT] = r_reg.op;
          rd[ibtq_pkg::CTRL_POLICY_BIT] = ibtq_pkg::POLICY_FIFO;
        end
        ibtq_pkg::OFS_BLOCKS: rd[NW-1:0] = r_reg.blocks_to_send;
        ibtq_pkg::OFS_CMD: rd = '0;
        ibtq_pkg::OFS_CAPACITY: rd = DW'(QUEUE_BLOCKS);
        ibtq_pkg::OFS_OCCUPANCY: rd[CW-1:0] = r_reg.queue_occupancy;
        ibtq_pkg::OFS_DROPPED: rd = r_reg.dropped_block_count;
        ibtq_pkg::OFS_STATUS:
        begin
          rd[ibtq_pkg::STAT_RUN_BIT] = r_reg.running;
          rd[ibtq_pkg::STAT_TX_BIT] = r_reg.tx_active;
        end
        default: rr = ibtq_pkg::RESP_SLVERR;
      endcase
      r_next.rvalid = 1'b1;
      r_next.rdata = rd;
      r_next.rresp = rr;
    end

    if (stream_close)
    begin
      mem_we = 1'b0;
      r_next.head = '0;
      r_next.tail = '0;
      r_next.queue_occupancy = '0;
      r_next.wr_busy = 1'b0;
      r_next.tx_active = 1'b0;
      r_next.running = 1'b0;
      r_next.slot_done = '0;
      r_next.slot_len = '0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      r_reg <= '0;
      r_reg.method <= ibtq_pkg::METHOD_BASIC;
      r_reg.op <= ibtq_pkg::OP_CONTINUOUS;
      r_reg.blocks_to_send <= ibtq_pkg::BLOCKS_RESET;
    end
    else
      r_reg <= r_next;
  end

  // The block store has no reset; only words below a slot's length are ever read.
  always_ff @(posedge clk)
  begin
    if (mem_we)
      mem[mem_waddr] <= blk_data;
  end

  ibtq_skid #(
    .W(DW + 1)
  ) u_out_buf (
    .clk(clk),
    .srst(srst),
    .flush(stream_close),
    .s_valid(push_valid),
    .s_data({push_last, mem[mem_raddr]}),
    .s_ready(push_ready),
    .m_valid(tx_valid),
    .m_data(skid_out),
    .m_ready(tx_ready)
  );
endmodule
